/* rtl/ppd_port_ctrl.sv */
// port direction and pad configuration top level
// Behaviour
// - each direction bit steers its own pin, zero meaning output and one meaning input.
// - the 8-bit direction register sits at 0xF231, is fully read/write and resets to zero.
// - the 16-bit pad config register sits at 0xF232, takes byte or halfword access and resets to zero.
// - a pin's pad field is low byte bit n as its low bit and high byte bit n+8 as its high bit.
// - in output mode fields 00,01,10,11 give high-z, P-channel open drain, N-channel open drain, push-pull.
// - in input mode fields 00 and 11 give plain input, 01 a pull-down and 10 a pull-up.
// - the direction bit of each pin picks which meaning its pad field has.
// - in output mode a pin's drive value follows its data register bit, which reads back as written.
// - in input mode a data register read returns the sampled pin level.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module ppd_port_ctrl (
	input wire logic ref_clk,
	input wire logic reset,
	input ppd_pkg::ppd_bus_req_t bus_req,
	output logic [15:0] bus_rdata,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe_n,
	output logic [7:0] pull_up_en,
	output logic [7:0] pull_down_en
);
	logic [7:0] port_data_reg;
	logic [7:0] pin_direction_reg;
	logic [7:0] pad_config_low_byte;
	logic [7:0] pad_config_high_byte;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic [7:0] pin_level;
	ppd_pkg::ppd_pad_ctrl_t pad_ctrl [ppd_pkg::PIN_COUNT];
	logic [7:0] out_reg;
	logic [7:0] oe_n_reg;
	logic [7:0] pu_reg;
	logic [7:0] pd_reg;

	function automatic logic hit(input ppd_pkg::ppd_bus_req_t r, input logic [15:0] a);
		hit = (r.addr == a);
	endfunction

	wire wr_data;
	wire wr_dir;
	wire wr_cfg_low;
	wire wr_cfg_high;
	assign wr_data = bus_req.wr && hit(bus_req, ppd_pkg::ADDR_DATA);
	assign wr_dir = bus_req.wr && hit(bus_req, ppd_pkg::ADDR_DIR);
	assign wr_cfg_low = bus_req.wr && hit(bus_req, ppd_pkg::ADDR_CFG_LOW);
	assign wr_cfg_high = bus_req.wr && (hit(bus_req, ppd_pkg::ADDR_CFG_HIGH) ||
		(bus_req.halfword && hit(bus_req, ppd_pkg::ADDR_CFG_LOW)));
	wire [7:0] high_wdata;
	assign high_wdata = (bus_req.halfword && hit(bus_req, ppd_pkg::ADDR_CFG_LOW)) ?
		bus_req.wdata[15:8] : bus_req.wdata[7:0];

	ppd_sync u_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.async_in(pin_in),
		.sync_out(pin_level)
	);

	// data read: written value on outputs, pin level on inputs
	wire [7:0] data_view;
	assign data_view = (port_data_reg & ~pin_direction_reg) | (pin_level & pin_direction_reg);

	always_comb begin
		rdata_next = 16'h0000;
		if (bus_req.rd) begin
			if (hit(bus_req, ppd_pkg::ADDR_DATA))
				rdata_next = {8'h00, data_view};
			else if (hit(bus_req, ppd_pkg::ADDR_DIR))
				rdata_next = {8'h00, pin_direction_reg};
			else if (hit(bus_req, ppd_pkg::ADDR_CFG_LOW))
				rdata_next = bus_req.halfword ? {pad_config_high_byte, pad_config_low_byte} :
					{8'h00, pad_config_low_byte};
			else if (hit(bus_req, ppd_pkg::ADDR_CFG_HIGH))
				rdata_next = {8'h00, pad_config_high_byte};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			port_data_reg <= ppd_pkg::DATA_RESET;
			pin_direction_reg <= ppd_pkg::DIR_RESET;
			pad_config_low_byte <= ppd_pkg::CFG_RESET[7:0];
			pad_config_high_byte <= ppd_pkg::CFG_RESET[15:8];
			rdata_reg <= 16'h0000;
		end else begin
			if (wr_data)
				port_data_reg <= bus_req.wdata[7:0];
			if (wr_dir)
				pin_direction_reg <= bus_req.wdata[7:0];
			if (wr_cfg_low)
				pad_config_low_byte <= bus_req.wdata[7:0];
			if (wr_cfg_high)
				pad_config_high_byte <= high_wdata;
			rdata_reg <= rdata_next;
		end
	end
	assign bus_rdata = rdata_reg;

	// per-pin decode; pin n takes config bits n and n+8
	genvar n;
	generate
		for (n = 0; n < ppd_pkg::PIN_COUNT; n++) begin : g_pin
			ppd_pad_decode u_dec (
				.dir_bit(pin_direction_reg[n]),
				.pad_field({pad_config_high_byte[n], pad_config_low_byte[n]}),
				.data_bit(port_data_reg[n]),
				.pad_ctrl(pad_ctrl[n])
			);
		end
	endgenerate

	logic [7:0] out_next;
	logic [7:0] oe_n_next;
	logic [7:0] pu_next;
	logic [7:0] pd_next;
	always_comb begin
		for (int i = 0; i < ppd_pkg::PIN_COUNT; i++) begin
			out_next[i] = pad_ctrl[i].drive_value;
			oe_n_next[i] = pad_ctrl[i].output_enable_n;
			pu_next[i] = pad_ctrl[i].pull_up_en;
			pd_next[i] = pad_ctrl[i].pull_down_en;
		end
	end

	// pad controls registered so every output comes from a flip-flop
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			out_reg <= 8'h00;
			oe_n_reg <= 8'hFF;
			pu_reg <= 8'h00;
			pd_reg <= 8'h00;
		end else begin
			out_reg <= out_next;
			oe_n_reg <= oe_n_next;
			pu_reg <= pu_next;
			pd_reg <= pd_next;
		end
	end
	assign pin_out = out_reg;
	assign pin_oe_n = oe_n_reg;
	assign pull_up_en = pu_reg;
	assign pull_down_en = pd_reg;

	a_dir_reset_value: assert property (@(posedge ref_clk) $past(reset) |-> pin_direction_reg == 8'h00)
		else $error("direction not cleared by reset");
	a_dir_write_back: assert property (@(posedge ref_clk) disable iff (reset)
		wr_dir ##1 bus_req.rd && hit(bus_req, ppd_pkg::ADDR_DIR) |=> bus_rdata[7:0] == $past(pin_direction_reg, 1))
		else $error("direction readback wrong");
	a_cfg_half_write: assert property (@(posedge ref_clk) disable iff (reset)
		bus_req.wr && bus_req.halfword && hit(bus_req, ppd_pkg::ADDR_CFG_LOW)
		|=> {pad_config_high_byte, pad_config_low_byte} == $past(bus_req.wdata))
		else $error("halfword config write lost");
	a_input_no_drive: assert property (@(posedge ref_clk) disable iff (reset)
		pin_direction_reg[0] |=> pin_oe_n[0])
		else $error("input pin driven");
	a_pull_up_sel: assert property (@(posedge ref_clk) disable iff (reset)
		pin_direction_reg[1] && {pad_config_high_byte[1], pad_config_low_byte[1]} == 2'h2 |=> pull_up_en[1] && !pull_down_en[1])
		else $error("pull-up not selected");
	a_cmos_drive: assert property (@(posedge ref_clk) disable iff (reset)
		!pin_direction_reg[2] && pad_config_high_byte[2] && pad_config_low_byte[2]
		|=> !pin_oe_n[2] && pin_out[2] == $past(port_data_reg[2]))
		else $error("push-pull pin not driven");
	a_nch_one_float: assert property (@(posedge ref_clk) disable iff (reset)
		!pin_direction_reg[3] && pad_config_high_byte[3] && !pad_config_low_byte[3] && port_data_reg[3]
		|=> pin_oe_n[3])
		else $error("n-channel drove a one");
	a_pch_zero_float: assert property (@(posedge ref_clk) disable iff (reset)
		!pin_direction_reg[4] && !pad_config_high_byte[4] && pad_config_low_byte[4] && !port_data_reg[4]
		|=> pin_oe_n[4])
		else $error("p-channel drove a zero");
	a_out_no_pull: assert property (@(posedge ref_clk) disable iff (reset)
		!pin_direction_reg[5] |=> !pull_up_en[5] && !pull_down_en[5])
		else $error("pull active on output");
	a_data_read_out: assert property (@(posedge ref_clk) disable iff (reset)
		bus_req.rd && hit(bus_req, ppd_pkg::ADDR_DATA) && !pin_direction_reg[6]
		|=> bus_rdata[6] == $past(port_data_reg[6]))
		else $error("data readback wrong");

	// register bus and pad reset checks
	a_cfg_low_byte: assert property (@(posedge ref_clk) disable iff (reset)
		bus_req.wr && !bus_req.halfword && hit(bus_req, ppd_pkg::ADDR_CFG_LOW)
		|=> pad_config_low_byte == $past(bus_req.wdata[7:0]))
		else $error("config low byte write lost");
	a_cfg_byte_keep: assert property (@(posedge ref_clk) disable iff (reset)
		bus_req.wr && !bus_req.halfword && hit(bus_req, ppd_pkg::ADDR_CFG_LOW)
		|=> pad_config_high_byte == $past(pad_config_high_byte))
		else $error("config high byte hit by byte write");
	a_cfg_high_byte: assert property (@(posedge ref_clk) disable iff (reset)
		bus_req.wr && hit(bus_req, ppd_pkg::ADDR_CFG_HIGH)
		|=> pad_config_high_byte == $past(bus_req.wdata[7:0]))
		else $error("config high byte write lost");
	a_cfg_half_read: assert property (@(posedge ref_clk) disable iff (reset)
		bus_req.rd && bus_req.halfword && hit(bus_req, ppd_pkg::ADDR_CFG_LOW)
		|=> bus_rdata == $past({pad_config_high_byte, pad_config_low_byte}))
		else $error("config halfword read wrong");
	a_cfg_low_read: assert property (@(posedge ref_clk) disable iff (reset)
		bus_req.rd && !bus_req.halfword && hit(bus_req, ppd_pkg::ADDR_CFG_LOW)
		|=> bus_rdata == {8'h00, $past(pad_config_low_byte)})
		else $error("config low byte read wrong");
	a_cfg_high_read: assert property (@(posedge ref_clk) disable iff (reset)
		bus_req.rd && hit(bus_req, ppd_pkg::ADDR_CFG_HIGH)
		|=> bus_rdata == {8'h00, $past(pad_config_high_byte)})
		else $error("config high byte read wrong");
	a_cfg_reset_zero: assert property (@(posedge ref_clk)
		reset |=> {pad_config_high_byte, pad_config_low_byte} == ppd_pkg::CFG_RESET)
		else $error("config not cleared by reset");
	a_dir_write: assert property (@(posedge ref_clk) disable iff (reset)
		wr_dir
		|=> pin_direction_reg == $past(bus_req.wdata[7:0]))
		else $error("direction write lost");
	a_dir_read: assert property (@(posedge ref_clk) disable iff (reset)
		bus_req.rd && hit(bus_req, ppd_pkg::ADDR_DIR)
		|=> bus_rdata == {8'h00, $past(pin_direction_reg)})
		else $error("direction read wrong");
	a_unmapped_read_zero: assert property (@(posedge ref_clk) disable iff (reset)
		bus_req.rd && !hit(bus_req, ppd_pkg::ADDR_DATA) && !hit(bus_req, ppd_pkg::ADDR_DIR) &&
		!hit(bus_req, ppd_pkg::ADDR_CFG_LOW) && !hit(bus_req, ppd_pkg::ADDR_CFG_HIGH)
		|=> bus_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_idle_rdata_zero: assert property (@(posedge ref_clk) disable iff (reset)
		!bus_req.rd |=> bus_rdata == 16'h0000)
		else $error("read data outside read cycle");
	a_data_write: assert property (@(posedge ref_clk) disable iff (reset)
		wr_data
		|=> port_data_reg == $past(bus_req.wdata[7:0]))
		else $error("data write lost");
	a_data_keep: assert property (@(posedge ref_clk) disable iff (reset)
		!wr_data
		|=> port_data_reg == $past(port_data_reg))
		else $error("data register changed unasked");
	a_data_reset_zero: assert property (@(posedge ref_clk)
		reset |=> port_data_reg == ppd_pkg::DATA_RESET)
		else $error("data not cleared by reset");
	a_pad_reset_idle: assert property (@(posedge ref_clk)
		reset |=> pin_oe_n == 8'hFF && pull_up_en == 8'h00 && pull_down_en == 8'h00)
		else $error("pads active after reset");

	// per-pin pad checks
	generate
		for (n = 0; n < ppd_pkg::PIN_COUNT; n++) begin : g_pin_chk
			wire [1:0] fld;
			assign fld = {pad_config_high_byte[n], pad_config_low_byte[n]};
			a_in_no_drive: assert property (@(posedge ref_clk) disable iff (reset)
				pin_direction_reg[n]
				|=> pin_oe_n[n])
				else $error("input pin driven");
			a_out_pull_off: assert property (@(posedge ref_clk) disable iff (reset)
				!pin_direction_reg[n]
				|=> !pull_up_en[n] && !pull_down_en[n])
				else $error("pull active on output");
			a_in_pull_down: assert property (@(posedge ref_clk) disable iff (reset)
				pin_direction_reg[n] && fld == ppd_pkg::FIELD_LOW_OPT
				|=> pull_down_en[n] && !pull_up_en[n])
				else $error("pull-down not selected");
			a_in_pull_up: assert property (@(posedge ref_clk) disable iff (reset)
				pin_direction_reg[n] && fld == ppd_pkg::FIELD_HIGH_OPT
				|=> pull_up_en[n] && !pull_down_en[n])
				else $error("pull-up not selected");
			a_in_plain_float: assert property (@(posedge ref_clk) disable iff (reset)
				pin_direction_reg[n] && (fld == ppd_pkg::FIELD_HIZ || fld == ppd_pkg::FIELD_FULL)
				|=> !pull_up_en[n] && !pull_down_en[n])
				else $error("plain input has a pull");
			a_out_hiz_float: assert property (@(posedge ref_clk) disable iff (reset)
				!pin_direction_reg[n] && fld == ppd_pkg::FIELD_HIZ
				|=> pin_oe_n[n])
				else $error("high-z output driven");
			a_pch_drive_high: assert property (@(posedge ref_clk) disable iff (reset)
				!pin_direction_reg[n] && fld == ppd_pkg::FIELD_LOW_OPT && port_data_reg[n]
				|=> !pin_oe_n[n] && pin_out[n])
				else $error("p-channel did not drive high");
			a_nch_drive_low: assert property (@(posedge ref_clk) disable iff (reset)
				!pin_direction_reg[n] && fld == ppd_pkg::FIELD_HIGH_OPT && !port_data_reg[n]
				|=> !pin_oe_n[n] && !pin_out[n])
				else $error("n-channel did not drive low");
			a_cmos_follow: assert property (@(posedge ref_clk) disable iff (reset)
				!pin_direction_reg[n] && fld == ppd_pkg::FIELD_FULL
				|=> !pin_oe_n[n] && pin_out[n] == $past(port_data_reg[n]))
				else $error("push-pull pin not driven");
			a_pin_out_data: assert property (@(posedge ref_clk) disable iff (reset)
				!pin_direction_reg[n]
				|=> pin_out[n] == $past(port_data_reg[n]))
				else $error("pin drive value wrong");
			a_in_read_level: assert property (@(posedge ref_clk) disable iff (reset)
				bus_req.rd && hit(bus_req, ppd_pkg::ADDR_DATA) && pin_direction_reg[n]
				|=> bus_rdata[n] == $past(pin_level[n]))
				else $error("input level read wrong");
		end
	endgenerate
endmodule

/* rtl/ppd_pkg.sv */
// package for the port pad direction control block
package ppd_pkg;
	localparam int PIN_COUNT = 8;
	localparam int ADDR_W = 16;
	localparam logic [15:0] ADDR_DATA = 16'hF230;
	localparam logic [15:0] ADDR_DIR = 16'hF231;
	localparam logic [15:0] ADDR_CFG_LOW = 16'hF232;
	localparam logic [15:0] ADDR_CFG_HIGH = 16'hF233;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam int CFG_HIGH_BASE = 8;
	localparam logic [1:0] FIELD_HIZ = 2'h0;
	localparam logic [1:0] FIELD_LOW_OPT = 2'h1;
	localparam logic [1:0] FIELD_HIGH_OPT = 2'h2;
	localparam logic [1:0] FIELD_FULL = 2'h3;
	localparam logic DIR_OUTPUT = 1'h0;

	typedef enum {
		PPD_HIZ,
		PPD_PCH_OD,
		PPD_NCH_OD,
		PPD_CMOS,
		PPD_IN_PLAIN,
		PPD_IN_PULLDOWN,
		PPD_IN_PULLUP
	} ppd_mode_t;

	// register bus request
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
		logic halfword;
	} ppd_bus_req_t;

	// per-pin pad cell controls
	typedef struct packed {
		logic drive_value;
		logic output_enable_n;
		logic pull_up_en;
		logic pull_down_en;
	} ppd_pad_ctrl_t;
endpackage

/* rtl/ppd_pad_decode.sv */
// one pin's pad mode decode
`timescale 1ns/1ps
module ppd_pad_decode (
	input wire logic dir_bit,
	input wire logic [1:0] pad_field,
	input wire logic data_bit,
	output ppd_pkg::ppd_pad_ctrl_t pad_ctrl
);
	ppd_pkg::ppd_mode_t mode;
	wire is_output;
	assign is_output = (dir_bit == ppd_pkg::DIR_OUTPUT);

	always_comb begin
		mode = ppd_pkg::PPD_HIZ;
		if (is_output) begin
			unique case (pad_field)
				ppd_pkg::FIELD_HIZ: mode = ppd_pkg::PPD_HIZ;
				ppd_pkg::FIELD_LOW_OPT: mode = ppd_pkg::PPD_PCH_OD;
				ppd_pkg::FIELD_HIGH_OPT: mode = ppd_pkg::PPD_NCH_OD;
				ppd_pkg::FIELD_FULL: mode = ppd_pkg::PPD_CMOS;
			endcase
		end else begin
			unique case (pad_field)
				ppd_pkg::FIELD_LOW_OPT: mode = ppd_pkg::PPD_IN_PULLDOWN;
				ppd_pkg::FIELD_HIGH_OPT: mode = ppd_pkg::PPD_IN_PULLUP;
				ppd_pkg::FIELD_HIZ, ppd_pkg::FIELD_FULL: mode = ppd_pkg::PPD_IN_PLAIN;
			endcase
		end
	end

	// open drain modes enable only one driver
	wire drive_on;
	assign drive_on = (mode == ppd_pkg::PPD_CMOS) ||
		(mode == ppd_pkg::PPD_PCH_OD && data_bit) ||
		(mode == ppd_pkg::PPD_NCH_OD && !data_bit);
	// one driver for the whole struct
	assign pad_ctrl = '{
		drive_value: data_bit,
		output_enable_n: !drive_on,
		pull_up_en: (mode == ppd_pkg::PPD_IN_PULLUP),
		pull_down_en: (mode == ppd_pkg::PPD_IN_PULLDOWN)
	};
endmodule

/* rtl/ppd_sync.sv */
// three-stage synchroniser for the pin inputs
`timescale 1ns/1ps
module ppd_sync (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] async_in,
	output logic [7:0] sync_out
);
	logic [7:0] meta_reg;
	logic [7:0] stage2_reg;
	logic [7:0] stage3_reg;
	logic [7:0] level_reg;
	wire [7:0] agree;
	assign agree = ~(stage2_reg ^ stage3_reg);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			meta_reg <= 8'h00;
			stage2_reg <= 8'h00;
			stage3_reg <= 8'h00;
			level_reg <= 8'h00;
		end else begin
			meta_reg <= async_in;
			stage2_reg <= meta_reg;
			stage3_reg <= stage2_reg;
			level_reg <= (agree & stage3_reg) | (~agree & level_reg);
		end
	end
	assign sync_out = level_reg;
endmodule

/* testbench/ppd_ext_circuit.sv */
// external pin circuitry: pad level resolution and an led on pin zero
`timescale 1ns/1ps
module ppd_ext_circuit (
	input wire logic ref_clk,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] pull_up_en,
	input wire logic [7:0] pull_down_en,
	output logic [7:0] pin_level,
	output logic led_on
);
	logic [7:0] float_reg = 8'h55;
	// undriven, unpulled pins wander every cycle
	always_ff @(posedge ref_clk) float_reg <= ~float_reg;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pin_oe_n[i]) pin_level[i] = pin_out[i];
			else if (pull_up_en[i]) pin_level[i] = 1'h1;
			else if (pull_down_en[i]) pin_level[i] = 1'h0;
			else pin_level[i] = float_reg[i];
		end
	end
	// led from supply into pin zero, lit while the pin sinks
	assign led_on = !pin_oe_n[0] && !pin_out[0];
endmodule

/* testbench/ppd_port_ctrl_bench.sv */
// self-checking bench for the port pad direction control block
`timescale 1ns/1ps
module ppd_port_ctrl_bench;
	logic ref_clk = 1'h0;
	logic reset = 1'h1;
	ppd_pkg::ppd_bus_req_t bus_req = '0;
	logic [15:0] bus_rdata, rv;
	logic [7:0] pin_in, pin_out, pin_oe_n, pull_up_en, pull_down_en;
	logic led_on;
	int n_fail = 0;
	int comparisons = 0;
	ppd_port_ctrl dut (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en));
	ppd_ext_circuit ext (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en), .pin_level(pin_in), .led_on(led_on));
	initial forever #4 ref_clk = ~ref_clk;
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("n_fail %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task bus_wr(input logic [15:0] a, input logic [15:0] d, input logic hw);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0, halfword: hw};
		@(posedge ref_clk);
		bus_req.wr <= 1'h0;
	endtask
	task bus_rd(input logic [15:0] a, input logic hw, output logic [15:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'h0, rd: 1'h1, halfword: hw};
		@(posedge ref_clk);
		bus_req.rd <= 1'h0;
		#1 d = bus_rdata;
	endtask
	task rd_chk(input logic [15:0] a, input logic hw, input logic [15:0] exp);
		bus_rd(a, hw, rv);
		chk(rv, exp);
	endtask
	// program direction, data and pad fields, then judge every enable and pull, the drive value of output pins and the data read of output and pulled pins
	task pads(input logic [7:0] dir, input logic [7:0] data, input logic [15:0] cfg);
		logic [7:0] oe, pu, pd, m;
		logic [1:0] f;
		bus_wr(ppd_pkg::ADDR_DATA, {8'h00, data}, 1'h0);
		bus_wr(ppd_pkg::ADDR_DIR, {8'h00, dir}, 1'h0);
		bus_wr(ppd_pkg::ADDR_CFG_LOW, cfg, 1'h1);
		repeat (2) @(posedge ref_clk);
		#1;
		for (int i = 0; i < 8; i++) begin
			f = {cfg[i + 8], cfg[i]};
			pu[i] = dir[i] && f == 2'h2;
			pd[i] = dir[i] && f == 2'h1;
			oe[i] = dir[i] || f == 2'h0 || (f == 2'h1 && !data[i]) || (f == 2'h2 && data[i]);
		end
		chk(pin_oe_n, oe);
		chk(pull_up_en, pu);
		chk(pull_down_en, pd);
		chk(pin_out & ~dir, data & ~dir);
		repeat (4) @(posedge ref_clk);
		bus_rd(ppd_pkg::ADDR_DATA, 1'h0, rv);
		m = ~dir | pu | pd;
		chk(rv & m, (data & ~dir | pu) & m);
	endtask
	task t_reset;
		chk(pin_oe_n, 8'hFF);
		chk(pull_up_en | pull_down_en, 8'h00);
		rd_chk(ppd_pkg::ADDR_DIR, 1'h0, ppd_pkg::DIR_RESET);
		rd_chk(ppd_pkg::ADDR_CFG_LOW, 1'h1, ppd_pkg::CFG_RESET);
	endtask
	task t_regs;
		bus_wr(ppd_pkg::ADDR_DIR, 16'h00A5, 1'h0);
		rd_chk(ppd_pkg::ADDR_DIR, 1'h0, 16'h00A5);
		bus_wr(ppd_pkg::ADDR_CFG_LOW, 16'h1234, 1'h1);
		rd_chk(ppd_pkg::ADDR_CFG_LOW, 1'h1, 16'h1234);
		bus_wr(ppd_pkg::ADDR_CFG_HIGH, 16'h0056, 1'h0);
		rd_chk(ppd_pkg::ADDR_CFG_LOW, 1'h1, 16'h5634);
		rd_chk(ppd_pkg::ADDR_CFG_HIGH, 1'h0, 16'h0056);
		bus_wr(ppd_pkg::ADDR_CFG_LOW, 16'h009A, 1'h0);
		rd_chk(ppd_pkg::ADDR_CFG_LOW, 1'h1, 16'h569A);
		bus_wr(16'hF236, 16'hFFFF, 1'h1);
		rd_chk(16'hF236, 1'h1, 16'h0000);
		rd_chk(ppd_pkg::ADDR_DIR, 1'h0, 16'h00A5);
		// write then read with no gap, then the read data must drop again
		@(posedge ref_clk);
		bus_req <= '{addr: ppd_pkg::ADDR_DIR, wdata: 16'h003C, wr: 1'h1, rd: 1'h0, halfword: 1'h0};
		@(posedge ref_clk);
		bus_req <= '{addr: ppd_pkg::ADDR_DIR, wdata: 16'h0000, wr: 1'h0, rd: 1'h1, halfword: 1'h0};
		@(posedge ref_clk);
		bus_req <= '0;
		#1 chk(bus_rdata, 16'h003C);
		@(posedge ref_clk);
		#1 chk(bus_rdata, 16'h0000);
	endtask
	task t_modes;
		for (int f = 0; f < 4; f++) begin
			pads(8'h00, 8'h5A, {{8{f[1]}}, {8{f[0]}}});
			pads(8'hFF, 8'h5A, {{8{f[1]}}, {8{f[0]}}});
		end
	endtask
	task t_mixed;
		pads(8'hF0, 8'hC3, 16'h3C96);
		pads(8'h00, 8'h00, 16'h00FF);
		pads(8'h00, 8'h00, 16'hFF00);
		chk(led_on, 1'h1);
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		reset <= 1'h0;
		t_reset();
		t_regs();
		t_modes();
		t_mixed();
		stop_test();
	end
	initial begin
		#100000;
		n_fail++;
		stop_test();
	end
endmodule
